// ---- design/tt3_timer.sv ----
// third timer unit: 16-bit up or up/down timer/counter with capture and
// reload, clock output, banked registers and an apb slave
// assumes one 125 MHz clock, synchronous reset, pins asynchronous
//
// The APB slave port was decided locally.
`include "tt3_map.svh"
`timescale 1ns/1ns

module tt3_timer (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire tt3_pkg::tt3_apb_req_t apbReq,
  output      tt3_pkg::tt3_apb_rsp_t apbRsp,
  input  wire logic                 auxPin,
  input  wire logic                 timerPinIn,
  output      logic                 timerPinOut,
  output      logic                 timerPinOe,
  output      logic                 irq,
  output      logic                 irqPriority,
  output      logic                 pwmRun
);

  tt3_pkg::tt3_state_t st_r;
  tt3_pkg::tt3_state_t st_nxt;

  // decoded bus and timer terms
  logic       access;
  logic       doWr;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] rd;
  logic       hit;
  logic       bankOk;
  logic       auxFall;
  logic       pinFall;
  logic       tick;
  logic       upDown;
  logic       trig;
  logic       ovf;
  logic       evOf;
  logic       evEx;

  // next state: synchronisers, apb slave, counter and interrupt
  always_comb begin
    st_nxt  = st_r;
    access  = apbReq.psel && apbReq.penable;
    doWr    = access && apbReq.pwrite && st_r.rsp.pready;
    idx     = apbReq.paddr[9:2];
    wd      = apbReq.pwdata[7:0];
    bankOk  = (st_r.bank == `TT3_BANK_SEL);
    rd      = 8'h00;
    hit     = (apbReq.paddr[11:10] == 2'h0);
    auxFall = 1'b0;
    pinFall = 1'b0;
    tick    = 1'b0;
    trig    = 1'b0;
    ovf     = 1'b0;
    evOf    = 1'b0;
    evEx    = 1'b0;

    // three-stage synchronisers; a change counts once stages two and
    // three agree, so a single glitchy sample is never taken
    st_nxt.auxS = {st_r.auxS[1:0], auxPin};
    st_nxt.pinS = {st_r.pinS[1:0], timerPinIn};
    if (st_r.auxS[2] == st_r.auxS[1]) begin
      st_nxt.auxL = st_r.auxS[2];
      auxFall     = st_r.auxL && !st_r.auxS[2];
    end
    if (st_r.pinS[2] == st_r.pinS[1]) begin
      st_nxt.pinL = st_r.pinS[2];
      pinFall     = st_r.pinL && !st_r.pinS[2];
    end

    // count source: prescaler runs only with the run bit set
    upDown = st_r.mode[`TT3_M_UD] && !st_r.ctrl[`TT3_C_CR];
    if (st_r.ctrl[`TT3_C_RUN]) begin
      if (st_r.pre == `TT3_PRE_TOP) begin
        st_nxt.pre = 4'h0;
      end else begin
        st_nxt.pre = st_r.pre + 4'h1;
      end
      if (st_r.ctrl[`TT3_C_CT]) begin
        // pin pulses count only while the pin is not an output
        tick = pinFall && !st_r.mode[`TT3_M_OE];
      end else if (st_r.mode[`TT3_M_BYP]) begin
        tick = 1'b1;
      end else begin
        tick = (st_r.pre == `TT3_PRE_TOP);
      end
    end

    // count step, overflow and auto-reload
    if (tick) begin
      if (upDown && !st_r.auxL) begin
        // down count: underflow at the reload value wraps to all ones
        if (st_r.cnt == st_r.rld) begin
          st_nxt.cnt = 16'hffff;
          ovf        = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end else if (st_r.cnt == 16'hffff) begin
        ovf = 1'b1;
        if (st_r.ctrl[`TT3_C_CR]) begin
          st_nxt.cnt = 16'h0000;
        end else begin
          st_nxt.cnt = st_r.rld;
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
    end

    // aux edge: ignored when gated off or when it steers direction
    trig = auxFall && st_r.ctrl[`TT3_C_GATE] && !upDown;
    if (trig) begin
      if (st_r.ctrl[`TT3_C_CR]) begin
        st_nxt.rld = st_r.cnt;
      end else begin
        st_nxt.cnt = st_r.rld;
      end
    end
    evOf = ovf;
    evEx = trig;

    // clock output toggles on each overflow
    if (ovf) begin
      st_nxt.clkO = !st_r.clkO;
    end

    // apb: one wait state, answer on the second access cycle
    st_nxt.rsp.pready  = access && !st_r.rsp.pready;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata  = 32'h0000_0000;
    if (hit) begin
      case (idx)
        `TT3_IDX_IE:     rd = st_r.ie;
        `TT3_IDX_IE1:    rd = st_r.ie1;
        `TT3_IDX_IP:     rd = st_r.ip;
        `TT3_IDX_IP1:    rd = st_r.ip1;
        `TT3_IDX_BANK:   rd = {5'h00, st_r.bank};
        `TT3_IDX_CTRL:   rd = bankOk ? st_r.ctrl : 8'h00;
        `TT3_IDX_MODE:   rd = bankOk ? st_r.mode : 8'h00;
        `TT3_IDX_RLD_LO: rd = bankOk ? st_r.rld[7:0] : 8'h00;
        `TT3_IDX_RLD_HI: rd = bankOk ? st_r.rld[15:8] : 8'h00;
        `TT3_IDX_CNT_LO: rd = bankOk ? st_r.cnt[7:0] : 8'h00;
        `TT3_IDX_CNT_HI: rd = bankOk ? st_r.cnt[15:8] : 8'h00;
        `TT3_IDX_STS:    rd = {6'h00, st_r.sts};
        `TT3_IDX_CLR:    rd = 8'h00;
        `TT3_IDX_IEN:    rd = {6'h00, st_r.ien};
        default:         hit = 1'b0;
      endcase
    end
    if (access && !st_r.rsp.pready) begin
      st_nxt.rsp.prdata  = {24'h00_0000, rd};
      st_nxt.rsp.pslverr = !hit;
    end

    // software writes; hardware events are merged afterwards
    if (doWr && hit) begin
      case (idx)
        `TT3_IDX_IE:   st_nxt.ie = wd;
        `TT3_IDX_IE1:  st_nxt.ie1 = wd & `TT3_IX1_MASK;
        `TT3_IDX_IP:   st_nxt.ip = wd & `TT3_IP_MASK;
        `TT3_IDX_IP1:  st_nxt.ip1 = wd & `TT3_IX1_MASK;
        `TT3_IDX_BANK: st_nxt.bank = wd[2:0];
        `TT3_IDX_CTRL: begin
          // reserved bits 5:4 stay zero
          if (bankOk) begin
            st_nxt.ctrl = {wd[7:6], 2'h0, wd[3:0]};
          end
        end
        `TT3_IDX_MODE: begin
          if (bankOk) begin
            st_nxt.mode = wd & `TT3_M_MASK;
          end
        end
        `TT3_IDX_RLD_LO: begin
          if (bankOk) begin
            st_nxt.rld[7:0] = wd;
          end
        end
        `TT3_IDX_RLD_HI: begin
          if (bankOk) begin
            st_nxt.rld[15:8] = wd;
          end
        end
        `TT3_IDX_CNT_LO: begin
          if (bankOk) begin
            st_nxt.cnt[7:0] = wd;
          end
        end
        `TT3_IDX_CNT_HI: begin
          if (bankOk) begin
            st_nxt.cnt[15:8] = wd;
          end
        end
        `TT3_IDX_CLR:  st_nxt.sts = st_r.sts & ~wd[1:0];
        `TT3_IDX_IEN:  st_nxt.ien = wd[1:0];
        default:       st_nxt.ien = st_r.ien;
      endcase
    end

    // hardware sets win over a software clear in the same cycle
    if (evOf) begin
      st_nxt.ctrl[`TT3_C_OF] = 1'b1;
      st_nxt.sts[`TT3_S_OF]  = 1'b1;
    end
    if (evEx) begin
      st_nxt.ctrl[`TT3_C_EX] = 1'b1;
      st_nxt.sts[`TT3_S_EX]  = 1'b1;
    end

    // interrupt level from the next state so it tracks without lag
    st_nxt.irq = (|(st_nxt.sts & st_nxt.ien))
                 && (st_nxt.ctrl[`TT3_C_OF] || st_nxt.ctrl[`TT3_C_EX])
                 && st_nxt.ie1[`TT3_IE1_T3]
                 && st_nxt.ie[`TT3_IE_GLOBAL];
  end

  // single state register; reset loads constants only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r      <= '0;
      st_r.bank <= `TT3_BANK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // all outputs straight from the state flops
  assign apbRsp      = st_r.rsp;
  assign irq         = st_r.irq;
  assign irqPriority = st_r.ip1[`TT3_IP1_T3];
  assign pwmRun      = st_r.ctrl[`TT3_C_RUN];
  assign timerPinOut = st_r.clkO;
  assign timerPinOe  = st_r.mode[`TT3_M_OE];

endmodule : tt3_timer

// ---- design/tt3_map.svh ----
// register indices, field positions, reset values and counts of the timer
// assumes a 32-bit apb word per register; byte address is index times four
`ifndef TT3_MAP_SVH
`define TT3_MAP_SVH

// register indices (byte address = index * 4)
`define TT3_IDX_IE      8'ha8
`define TT3_IDX_IE1     8'ha9
`define TT3_IDX_IP      8'hb8
`define TT3_IDX_IP1     8'hb9
`define TT3_IDX_CTRL    8'hc8
`define TT3_IDX_MODE    8'hc9
`define TT3_IDX_RLD_LO  8'hca
`define TT3_IDX_RLD_HI  8'hcb
`define TT3_IDX_CNT_LO  8'hcc
`define TT3_IDX_CNT_HI  8'hcd
`define TT3_IDX_BANK    8'hce
`define TT3_IDX_STS     8'hd0
`define TT3_IDX_CLR     8'hd1
`define TT3_IDX_IEN     8'hd2

// bank pointer value that selects this timer, and its reset value
`define TT3_BANK_SEL    3'h3
`define TT3_BANK_RST    3'h2

// control register bit positions
`define TT3_C_OF        7
`define TT3_C_EX        6
`define TT3_C_GATE      3
`define TT3_C_RUN       2
`define TT3_C_CT        1
`define TT3_C_CR        0

// mode register bit positions and writable mask
`define TT3_M_BYP       7
`define TT3_M_OE        1
`define TT3_M_UD        0
`define TT3_M_MASK      8'hbf

// interrupt bit positions
`define TT3_IE_GLOBAL   7
`define TT3_IE1_T3      6
`define TT3_IP1_T3      6
`define TT3_IP_MASK     8'h7f
`define TT3_IX1_MASK    8'hdf

// status/enable layout: bit 0 overflow, bit 1 external event
`define TT3_S_OF        0
`define TT3_S_EX        1

// prescaler: system clock divided by twelve
`define TT3_PRE_DIV     12
`define TT3_PRE_TOP     4'hb

`endif

// ---- design/tt3_pkg.sv ----
// types shared by the third timer unit: apb carriers and the state record
// assumes the constants of tt3_map.svh for all numeric values
package tt3_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tt3_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tt3_apb_rsp_t;

  typedef struct packed {
    logic [7:0]   ie;
    logic [7:0]   ie1;
    logic [7:0]   ip;
    logic [7:0]   ip1;
    logic [2:0]   bank;
    logic [7:0]   ctrl;
    logic [7:0]   mode;
    logic [15:0]  cnt;
    logic [15:0]  rld;
    logic [3:0]   pre;
    logic [1:0]   sts;
    logic [1:0]   ien;
    logic [2:0]   auxS;
    logic         auxL;
    logic [2:0]   pinS;
    logic         pinL;
    logic         clkO;
    logic         irq;
    tt3_apb_rsp_t rsp;
  } tt3_state_t;

endpackage : tt3_pkg

// ---- tb/tt3_pin_model.sv ----
// far side of the timer: drives the auxiliary and timer pins
// assumes the bench asks for levels held at least 3 cycles
`timescale 1ns/1ns
module tt3_pin_model (
  input  wire logic clock,
  input  wire logic auxReq,
  input  wire logic tpReq,
  output      logic auxPin,
  output      logic timerPinIn
);
  // pins follow requests one edge later, like board wiring
  always_ff @(posedge clock) begin
    auxPin     <= auxReq;
    timerPinIn <= tpReq;
  end
endmodule : tt3_pin_model

// ---- tb/tt3_timer_sva.sv ----
// concurrent checks on the ports of the third timer unit
// assumes one clock domain; bound to every tt3_timer
`timescale 1ns/1ns
module tt3_timer_sva (
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire tt3_pkg::tt3_apb_req_t apbReq,
  input wire tt3_pkg::tt3_apb_rsp_t apbRsp,
  input wire logic                  timerPinOe,
  input wire logic                  irq,
  input wire logic                  irqPriority,
  input wire logic                  pwmRun
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic       acc;
  logic [7:0] idx;
  // completed write and its register index
  assign acc = apbRsp.pready && apbReq.pwrite;
  assign idx = apbReq.paddr[9:2];
  a_rsp_one_wait: assert property (apbReq.psel && apbReq.penable &&
    !apbRsp.pready |=> apbRsp.pready) else $error("late ready");
  a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held");
  a_ready_in_access: assert property (apbRsp.pready |->
    apbReq.psel && apbReq.penable) else $error("stray ready");
  a_err_unmapped: assert property (apbRsp.pready && idx < 8'ha8 |->
    apbRsp.pslverr) else $error("no error");
  a_rdata_upper: assert property (apbRsp.pready |->
    apbRsp.prdata[31:8] == 24'h0) else $error("upper data");
  a_prio_follow: assert property (acc && idx == 8'hb9 &&
    apbReq.pwdata[6] |-> ##2 irqPriority) else $error("prio");
  a_irq_global_off: assert property (acc && idx == 8'ha8 &&
    !apbReq.pwdata[7] |-> ##2 !irq[*2]) else $error("irq");
  a_oe_by_write: assert property (!$past(acc) && !$past(acc, 2) |->
    $stable(timerPinOe)) else $error("oe moved");
  a_run_by_write: assert property ($changed(pwmRun) |->
    $past(acc) || $past(acc, 2)) else $error("run moved");
endmodule : tt3_timer_sva

bind tt3_timer tt3_timer_sva chk (
  .clock(clock), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
  .timerPinOe(timerPinOe), .irq(irq), .irqPriority(irqPriority),
  .pwmRun(pwmRun)
);

// ---- tb/testbench.sv ----
// self-checking bench of the third timer unit over apb
// assumes tt3_pin_model drives the pins; checker bound separately
`timescale 1ns/1ns
module testbench;
  logic                  clock, sys_rst, auxReq, tpReq, auxPin, tpModel;
  logic                  timerPinOut, timerPinOe, tpWire, irq;
  logic                  irqPriority, pwmRun, er;
  tt3_pkg::tt3_apb_req_t apbReq;
  tt3_pkg::tt3_apb_rsp_t apbRsp;
  logic [31:0]           rd;
  logic [7:0]            rl, pr, c;
  int                    n_mismatch, samples_checked, ex;
  // shared pin: the timer wins while its enable is high
  assign tpWire = timerPinOe ? timerPinOut : tpModel;
  tt3_timer uut (.clock(clock), .sys_rst(sys_rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .auxPin(auxPin), .timerPinIn(tpWire),
    .timerPinOut(timerPinOut), .timerPinOe(timerPinOe), .irq(irq),
    .irqPriority(irqPriority), .pwmRun(pwmRun));
  tt3_pin_model pins (.clock(clock), .auxReq(auxReq), .tpReq(tpReq),
    .auxPin(auxPin), .timerPinIn(tpModel));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; waits for ready under a bound
  task automatic xf(input logic w, input logic [7:0] i, d);
    int n = 0;
    apbReq <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    // ready is looked at mid-cycle, where it has settled
    do begin
      @(negedge clock);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    // request held through the edge that samples ready high
    @(posedge clock);
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
    // one idle edge so the next setup never overwrites the release
    @(posedge clock);
    if (n >= 50) n_mismatch++;
  endtask : xf
  // low pulse of 6 cycles, wide enough for the synchroniser
  task automatic pulse(input logic a);
    if (a) auxReq <= 1'b0;
    else tpReq <= 1'b0;
    repeat (6) @(posedge clock);
    auxReq <= 1'b1;
    tpReq  <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : pulse
  initial begin
    apbReq = '0;
    auxReq = 1'b1;
    tpReq = 1'b1;
    sys_rst = 1'b1;
    void'($urandom(87310));
    rl = 8'($urandom % 128);
    pr = 8'($urandom);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    xf(0, 8'hce, 0); chk("bank", rd, 32'h2);
    xf(0, 8'hc8, 0); chk("other", rd, 32'h0);
    xf(0, 8'h10, 0); chk("err", er, 1'b1);
    xf(1, 8'hb9, pr);
    repeat (2) @(posedge clock);
    chk("prio", irqPriority, pr[6]);
    xf(1, 8'hce, 8'h03);
    xf(1, 8'hca, rl); xf(1, 8'hcb, 8'h12);
    xf(1, 8'hcc, 8'hf0); xf(1, 8'hcd, 8'hff);
    xf(1, 8'ha8, 8'h80); xf(1, 8'hd2, 8'h01); xf(1, 8'hc9, 8'h80);
    xf(1, 8'hc8, 8'h04);
    repeat (40) @(posedge clock);
    chk("masked", irq, 1'b0);
    xf(1, 8'ha9, 8'h40);
    repeat (2) @(posedge clock);
    chk("irq", irq, 1'b1);
    chk("run", pwmRun, 1'b1);
    chk("clkout", timerPinOut, 1'b1);
    xf(0, 8'hc8, 0); chk("ovf", rd[7], 1'b1);
    xf(0, 8'hd0, 0); chk("sts", rd[0], 1'b1);
    xf(1, 8'hc8, 0); xf(1, 8'hd1, 8'h01);
    repeat (2) @(posedge clock);
    chk("clr", irq, 1'b0);
    xf(0, 8'hcd, 0); chk("reload", rd, 32'h12);
    xf(0, 8'hcc, 0); c = rd[7:0];
    xf(0, 8'hcc, 0); chk("frozen", rd, {24'h0, c});
    // divided then undivided source over the same window
    for (int i = 0; i < 2; i++) begin
      xf(1, 8'hcc, 0); xf(1, 8'hcd, 0); xf(1, 8'hc9, i ? 8'h80 : 8'h00);
      xf(1, 8'hc8, 8'h04);
      repeat (120) @(posedge clock);
      xf(1, 8'hc8, 0); xf(0, 8'hcc, 0);
      ex = i ? 123 : 10;
      chk("rate", rd + 2 >= ex && rd <= ex + 2, 1'b1);
    end
    xf(1, 8'hca, 0); xf(1, 8'hcb, 0); xf(1, 8'hcc, 0); xf(1, 8'hcd, 1);
    xf(1, 8'hc9, 8'h80); xf(1, 8'hc8, 8'h05);
    pulse(1);
    xf(0, 8'hc8, 0); chk("gate", rd[6], 1'b0);
    xf(1, 8'hc8, 8'h0d);
    pulse(1);
    xf(0, 8'hc8, 0); chk("exf", rd[6], 1'b1);
    xf(1, 8'hc8, 0);
    xf(0, 8'hcb, 0); chk("capt", rd, 32'h1);
    xf(1, 8'hcc, 0); xf(1, 8'hcd, 0); xf(1, 8'hc9, 0);
    xf(1, 8'hc8, 8'h06);
    repeat (5) pulse(0);
    xf(1, 8'hc8, 0);
    xf(0, 8'hcc, 0); chk("pins", rd, 32'h5);
    xf(1, 8'hc9, 8'h02);
    repeat (2) @(posedge clock);
    chk("oe", timerPinOe, 1'b1);
    xf(1, 8'hc9, 8'h81); xf(1, 8'hcc, 0); xf(1, 8'hcd, 8'h10);
    auxReq <= 1'b0;
    xf(1, 8'hc8, 8'h04);
    repeat (20) @(posedge clock);
    xf(1, 8'hc8, 0);
    xf(0, 8'hcd, 0); chk("down", rd, 32'hf);
    xf(1, 8'ha8, 8'h00);
    repeat (2) @(posedge clock);
    chk("global", irq, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
